/* File: rtl/ect_top.sv */
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module ect_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        edge_input_pin,
  input  wire logic        hosc_en,
  output logic             waveform_pin_o,
  output logic             waveform_pin_oe,
  // interrupt request
  output logic             timer_irq
);
  ect_tick_if t ();

  // register state
  logic [7:0]  mode_r;
  logic [7:0]  btmode_r;
  logic [7:0]  count_r;
  logic [7:0]  hold_r;
  logic [7:0]  active_r;
  logic        ovf_flag_r;
  logic        pin_flag_r;
  logic        ien_r;
  logic        toggle_r;
  // bus state
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        wave_r;
  logic        wave_oe_r;
  logic        irq_r;
  // decoded
  logic        acc;
  logic        fire;
  logic        wr_mode;
  logic        wr_bt;
  logic        wr_count;
  logic        wr_reload;
  logic        wr_status;
  logic        mapped;
  logic [31:0] rd_val;
  logic        pwm_en;
  logic        tog_en;
  logic        ext_sel;
  logic        reload_act;
  logic [7:0]  mask;
  logic        ovf;
  logic        pwm_lvl;
  logic [7:0]  count_nxt;

  // word address decode, shared by read and write paths
  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

  ect_tick u_tick (
    .clk            (clk),
    .rst_n          (rst_n),
    .edge_input_pin (edge_input_pin),
    .hosc_en        (hosc_en),
    .t              (t)
  );

  // mode fields feeding the tick generator
  assign pwm_en    = mode_r[ect_pkg::MB_PWM];
  assign tog_en    = mode_r[ect_pkg::MB_TOG] & ~pwm_en;
  assign ext_sel   = mode_r[ect_pkg::MB_CKS] & ~btmode_r[ect_pkg::BT_OVR];
  assign t.rate    = mode_r[ect_pkg::MB_RATE +: 3];
  assign t.ext_sel = mode_r[ect_pkg::MB_CKS];
  assign t.hosc_sel  = btmode_r[ect_pkg::BT_OVR];
  assign t.hosc_div1 = btmode_r[ect_pkg::BT_DIV];

  // the counter reloads only outside pwm; in pwm the count wraps to zero so the
  // duty stays reference over period, and only the reference itself reloads
  assign reload_act = ~pwm_en & mode_r[ect_pkg::MB_ALOAD];

  // overflow boundary; the external source always wraps at 256
  always_comb begin
    if (ext_sel || !pwm_en) begin
      mask = ect_pkg::MASK_256;
    end else begin
      unique case ({mode_r[ect_pkg::MB_ALOAD], mode_r[ect_pkg::MB_TOG]})
        2'b00: mask = ect_pkg::MASK_256;
        2'b01: mask = ect_pkg::MASK_64;
        2'b10: mask = ect_pkg::MASK_32;
        2'b11: mask = ect_pkg::MASK_16;
      endcase
    end
  end

  // overflow when a gated tick finds the count at the boundary
  assign ovf = mode_r[ect_pkg::MB_ENB] & t.cnt_tick &
               ((count_r & mask) == mask);

  // apb phases: first access cycle answers, second (pready high) commits
  assign acc    = psel & penable & ~pready_r;
  assign fire   = psel & penable & pready_r & pwrite;
  assign mapped = reg_hit(paddr, ect_pkg::IDX_RELOAD) |
                  reg_hit(paddr, ect_pkg::IDX_BTMODE) |
                  reg_hit(paddr, ect_pkg::IDX_MODE) |
                  reg_hit(paddr, ect_pkg::IDX_COUNT) |
                  reg_hit(paddr, ect_pkg::IDX_STATUS);
  assign wr_mode   = fire & reg_hit(paddr, ect_pkg::IDX_MODE);
  assign wr_bt     = fire & reg_hit(paddr, ect_pkg::IDX_BTMODE);
  assign wr_count  = fire & reg_hit(paddr, ect_pkg::IDX_COUNT);
  assign wr_reload = fire & reg_hit(paddr, ect_pkg::IDX_RELOAD);
  assign wr_status = fire & reg_hit(paddr, ect_pkg::IDX_STATUS);

  // read mux; the reload register is write-only and reads zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_hit(paddr, ect_pkg::IDX_BTMODE)) begin
      rd_val[7:0] = btmode_r;
    end else if (reg_hit(paddr, ect_pkg::IDX_MODE)) begin
      rd_val[7:0] = mode_r;
    end else if (reg_hit(paddr, ect_pkg::IDX_COUNT)) begin
      rd_val[7:0] = count_r;
    end else if (reg_hit(paddr, ect_pkg::IDX_STATUS)) begin
      rd_val[ect_pkg::ST_OVF] = ovf_flag_r;
      rd_val[ect_pkg::ST_PIN] = pin_flag_r;
      rd_val[ect_pkg::ST_IEN] = ien_r;
    end
  end

  // bus answer registers: one wait state on every access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc & ~mapped;
      if (acc && !pwrite) begin
        prdata_r <= rd_val;
      end
    end
  end

  // mode registers; basic timer bits 1:0 are masked off on write and read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r   <= ect_pkg::RST_MODE;
      btmode_r <= ect_pkg::RST_BTMODE;
    end else begin
      if (wr_mode) begin
        mode_r <= pwdata[7:0];
      end
      if (wr_bt) begin
        btmode_r <= pwdata[7:0] & ect_pkg::BT_WMASK;
      end
    end
  end

  // counter next value; the new reload enters the counter with it
  always_comb begin
    count_nxt = count_r;
    if (ovf) begin
      if (reload_act) begin
        count_nxt = hold_r & mask;
      end else begin
        count_nxt = 8'h00;
      end
    end else if (mode_r[ect_pkg::MB_ENB] && t.cnt_tick) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // live count; a software write wins over counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= ect_pkg::RST_COUNT;
    end else if (wr_count) begin
      count_r <= pwdata[7:0];
    end else begin
      count_r <= count_nxt;
    end
  end

  // double buffer: writes only reach the active stage at overflow,
  // so a period in progress never sees a half-changed reference
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r   <= ect_pkg::RST_RELOAD;
      active_r <= ect_pkg::RST_RELOAD;
    end else begin
      if (wr_reload) begin
        hold_r <= pwdata[7:0];
      end
      if (ovf) begin
        active_r <= hold_r;
      end
    end
  end

  // status flags: a set in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_r <= 1'b0;
      pin_flag_r <= 1'b0;
      ien_r      <= 1'b0;
    end else begin
      ovf_flag_r <= ovf | (ovf_flag_r &
                    ~(wr_status & pwdata[ect_pkg::ST_OVF]));
      if (ext_sel) begin
        pin_flag_r <= 1'b0;
      end else begin
        pin_flag_r <= t.pin_fall | (pin_flag_r &
                      ~(wr_status & pwdata[ect_pkg::ST_PIN]));
      end
      if (wr_status) begin
        ien_r <= pwdata[ect_pkg::ST_IEN];
      end
    end
  end

  // toggle output flips on each overflow, giving half the overflow rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_r <= 1'b0;
    end else if (ovf) begin
      toggle_r <= ~toggle_r;
    end
  end

  // pwm compare against the active reference; zero holds the pin low
  assign pwm_lvl = count_r < active_r;

  // output pin and request registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_r    <= 1'b0;
      wave_oe_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      wave_r    <= pwm_en ? pwm_lvl : toggle_r;
      wave_oe_r <= pwm_en | tog_en;
      irq_r     <= ovf_flag_r & ien_r;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign waveform_pin_o  = wave_r;
  assign waveform_pin_oe = wave_oe_r;
  assign timer_irq       = irq_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_ovf_flag_set: assert property (
    ovf |=> ovf_flag_r ##1 irq_r == $past(ien_r))
    else $error("overflow flag or request missing");
  a_flag_sticky: assert property (
    ovf_flag_r && !wr_status |=> ovf_flag_r)
    else $error("overflow flag dropped without a clear");
  a_wrap_zero: assert property (
    ovf && !reload_act && !wr_count |=> count_r == 8'h00)
    else $error("counter did not wrap to zero");
  a_reload_copy: assert property (
    ovf && reload_act && !wr_count |=> count_r == ($past(hold_r) & $past(mask)))
    else $error("reload value not copied");
  a_active_hold: assert property (
    !ovf |=> active_r == $past(active_r))
    else $error("active reload changed without overflow");
  a_active_take: assert property (
    ovf |=> active_r == $past(hold_r))
    else $error("holding buffer not moved on overflow");
  a_stop_freeze: assert property (
    !mode_r[ect_pkg::MB_ENB] && !wr_count |=> count_r == $past(count_r))
    else $error("counter moved while stopped");
  a_ext_bound: assert property (
    ext_sel |-> mask == ect_pkg::MASK_256)
    else $error("external source boundary not 256");
  a_pwm_bound16: assert property (
    pwm_en && !ext_sel && mode_r[ect_pkg::MB_ALOAD] && mode_r[ect_pkg::MB_TOG]
    |-> mask == ect_pkg::MASK_16)
    else $error("pwm boundary not 16");
  a_pin_flag_off: assert property (
    ext_sel |=> !pin_flag_r)
    else $error("pin flag set under external source");
  a_pwm_level: assert property (
    pwm_en |=> wave_r == ($past(count_r) < $past(active_r)))
    else $error("pwm level wrong");
  a_toggle_flip: assert property (
    ovf |=> toggle_r != $past(toggle_r))
    else $error("toggle did not flip");
  a_apb_answer: assert property (
    psel && penable && !pready_r |=> pready_r ##1 !pready_r)
    else $error("apb answer not one cycle");
  a_count_step: assert property (
    mode_r[ect_pkg::MB_ENB] && t.cnt_tick && !ovf && !wr_count
    |=> count_r == $past(count_r) + 8'h01)
    else $error("counter did not step by one");
  a_count_write: assert property (
    wr_count |=> count_r == $past(pwdata[7:0]))
    else $error("written count not taken");
  a_hold_write: assert property (
    wr_reload |=> hold_r == $past(pwdata[7:0]))
    else $error("reload write missed the holding buffer");
  a_pwm_wrap: assert property (
    pwm_en && ovf && !wr_count |=> count_r == 8'h00)
    else $error("pwm counter did not wrap to zero");
  a_pwm_bound256: assert property (
    pwm_en && !ext_sel && !mode_r[ect_pkg::MB_ALOAD] && !mode_r[ect_pkg::MB_TOG]
    |-> mask == ect_pkg::MASK_256)
    else $error("pwm boundary not 256");
  a_pwm_bound64: assert property (
    pwm_en && !ext_sel && !mode_r[ect_pkg::MB_ALOAD] && mode_r[ect_pkg::MB_TOG]
    |-> mask == ect_pkg::MASK_64)
    else $error("pwm boundary not 64");
  a_pwm_bound32: assert property (
    pwm_en && !ext_sel && mode_r[ect_pkg::MB_ALOAD] && !mode_r[ect_pkg::MB_TOG]
    |-> mask == ect_pkg::MASK_32)
    else $error("pwm boundary not 32");
  a_int_bound: assert property (
    !pwm_en |-> mask == ect_pkg::MASK_256)
    else $error("boundary not 256 outside pwm");
  a_pin_flag_set: assert property (
    t.pin_fall && !ext_sel |=> pin_flag_r)
    else $error("pin flag not set by an edge");
  a_tog_pin: assert property (
    !pwm_en |=> wave_r == $past(toggle_r))
    else $error("pin does not follow the toggle");
  a_tog_oe: assert property (
    tog_en |=> wave_oe_r)
    else $error("toggle output not driving the pin");
  a_oe_off: assert property (
    !pwm_en && !tog_en |=> !wave_oe_r)
    else $error("pin driven with both outputs off");
  a_irq_gate: assert property (
    !ien_r |=> !irq_r)
    else $error("request raised while disabled");
  a_err_unmapped: assert property (
    acc && !mapped |=> pslverr_r)
    else $error("unmapped access without error");

  c_pwm_ovf: cover property (pwm_en && ovf);
  c_ext_count: cover property (ext_sel && t.cnt_tick && mode_r[ect_pkg::MB_ENB]);
  c_reload_run: cover property (wr_reload && mode_r[ect_pkg::MB_ENB] ##[1:300] ovf);
  c_set_clear: cover property (ovf && wr_status && pwdata[ect_pkg::ST_OVF]);
endmodule

/* File: rtl/ect_pkg.sv */
package ect_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RELOAD = 8'hCD;
  localparam logic [7:0] IDX_BTMODE = 8'hD8;
  localparam logic [7:0] IDX_MODE   = 8'hDA;
  localparam logic [7:0] IDX_COUNT  = 8'hDB;
  localparam logic [7:0] IDX_STATUS = 8'hE0;
  // counter_mode fields
  localparam int MB_PWM    = 0;
  localparam int MB_TOG    = 1;
  localparam int MB_ALOAD  = 2;
  localparam int MB_CKS    = 3;
  localparam int MB_RATE   = 4;
  localparam int MB_ENB    = 7;
  // basic_timer_mode fields
  localparam int BT_OVR    = 2;
  localparam int BT_DIV    = 3;
  localparam logic [7:0] BT_WMASK = 8'hFC;
  // status fields
  localparam int ST_OVF    = 0;
  localparam int ST_PIN    = 1;
  localparam int ST_IEN    = 4;
  // reset values
  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [7:0] RST_BTMODE = 8'h00;
  localparam logic [7:0] RST_COUNT  = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  // overflow boundary masks
  localparam logic [7:0] MASK_256 = 8'hFF;
  localparam logic [7:0] MASK_64  = 8'h3F;
  localparam logic [7:0] MASK_32  = 8'h1F;
  localparam logic [7:0] MASK_16  = 8'h0F;
  // prescaler reaches divide-by-256
  localparam int PRE_W = 8;
endpackage

/* File: rtl/ect_tick_if.sv */
`timescale 1ns/10ps
interface ect_tick_if;
  logic [2:0] rate;
  logic       ext_sel;
  logic       hosc_sel;
  logic       hosc_div1;
  logic       cnt_tick;
  logic       pin_fall;
  modport gen  (input rate, ext_sel, hosc_sel, hosc_div1, output cnt_tick, pin_fall);
  modport core (output rate, ext_sel, hosc_sel, hosc_div1, input cnt_tick, pin_fall);
endinterface

/* File: rtl/ect_tick.sv */
`timescale 1ns/10ps
module ect_tick (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin and oscillator enable
  input  wire logic edge_input_pin,
  input  wire logic hosc_en,
  // ticks to the counter
  ect_tick_if.gen   t
);
  logic [ect_pkg::PRE_W-1:0] pre_r;
  logic                      sy1_r;
  logic                      sy2_r;
  logic                      sy3_r;
  logic                      hdiv_r;
  logic                      fall;
  logic                      int_hit;
  logic                      cnt_tick_r;
  logic                      pin_fall_r;

  // low bits all ones once per 256 >> rate cycles
  function automatic logic rate_hit(input logic [7:0] p, input logic [2:0] r);
    logic [7:0] m;
    m = 8'hFF >> r;
    return (p & m) == m;
  endfunction

  // two-stage synchroniser, third stage only for the edge compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= 1'b1;
      sy2_r <= 1'b1;
      sy3_r <= 1'b1;
    end else begin
      sy1_r <= edge_input_pin;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end
  assign fall = sy3_r & ~sy2_r;

  // free-running prescaler and oscillator halver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r  <= '0;
      hdiv_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 8'h01;
      if (hosc_en) begin
        hdiv_r <= ~hdiv_r;
      end
    end
  end

  // source priority: override, then external pin, then prescaler
  always_comb begin
    if (t.hosc_sel) begin
      int_hit = hosc_en & (t.hosc_div1 | hdiv_r);
    end else if (t.ext_sel) begin
      int_hit = fall;
    end else begin
      int_hit = rate_hit(pre_r, t.rate);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_tick_r <= 1'b0;
      pin_fall_r <= 1'b0;
    end else begin
      cnt_tick_r <= int_hit;
      pin_fall_r <= fall;
    end
  end
  assign t.cnt_tick = cnt_tick_r;
  assign t.pin_fall = pin_fall_r;

  a_edge_single: assert property (@(posedge clk) disable iff (!rst_n)
    pin_fall_r |=> !pin_fall_r) else $error("edge counted twice");
  a_rate_fastest: assert property (@(posedge clk) disable iff (!rst_n)
    (!t.hosc_sel && !t.ext_sel && t.rate == 3'h7 && pre_r[0])
    |=> cnt_tick_r) else $error("divide by two tick missing");
endmodule

/* File: sim/timer_counter_pwm_buzzer_tb_top.sv */
`timescale 1ns/10ps
module timer_counter_pwm_buzzer_tb_top;
  // clock, reset and bus
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // pins
  logic        edge_input_pin;
  logic        hosc_en;
  logic        waveform_pin_o;
  logic        waveform_pin_oe;
  logic        timer_irq;
  // bookkeeping
  int          n_fail;
  int          n_compared;
  int          cyc;
  int          nb;
  logic [64:0] q[$];
  logic [64:0] note;
  logic [31:0] v;
  int          d;
  int          bnd;
  int          h;
  logic        lvl;
  // short aliases for register indices
  localparam logic [7:0] RR = ect_pkg::IDX_RELOAD;
  localparam logic [7:0] RB = ect_pkg::IDX_BTMODE;
  localparam logic [7:0] RM = ect_pkg::IDX_MODE;
  localparam logic [7:0] RC = ect_pkg::IDX_COUNT;
  localparam logic [7:0] RS = ect_pkg::IDX_STATUS;

  ect_top u_ect_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .edge_input_pin(edge_input_pin), .hosc_en(hosc_en),
    .waveform_pin_o(waveform_pin_o), .waveform_pin_oe(waveform_pin_oe),
    .timer_irq(timer_irq));

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask

  // timeout: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  // answer watcher: every pready pulse retires the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) chk("unasked answer", 32'h0, 32'h1);
      else begin
        note = q.pop_front();
        chk("read data", note[31:0], prdata & note[63:32]);
        chk("slave error", {31'h0, note[64]}, {31'h0, pslverr});
      end
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] dt,
                     input logic [31:0] m, input logic [31:0] e, input logic er);
    nb = 1;
    q.push_back({er, m, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      nb++;
    end while (pready !== 1'b1 && nb < 40);
    if (nb >= 40) n_fail++;
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    nb++;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] dt);
    acc(1'b1, i, {24'h0, dt}, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    acc(1'b0, i, 32'h0, {24'h0, m}, {24'h0, e}, 1'b0);
  endtask

  // one falling edge on the event pin, held long enough for the synchroniser
  task automatic fall();
    edge_input_pin <= 1'b0;
    cy(5);
    edge_input_pin <= 1'b1;
    cy(5);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    edge_input_pin = 1'b1;
    hosc_en = 1'b0;
    rst_n = 1'b0;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    v = $urandom(12);
    cy(12);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values and access kinds
    chk("pin enable", 32'h0, {31'h0, waveform_pin_oe});
    rd(RM, 8'hFF, ect_pkg::RST_MODE);
    rd(RB, 8'hFF, ect_pkg::RST_BTMODE);
    rd(RC, 8'hFF, ect_pkg::RST_COUNT);
    rd(RR, 8'hFF, 8'h00);
    rd(RS, 8'hFF, 8'h00);
    acc(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    acc(1'b1, 8'h11, 32'hFF, 32'h0, 32'h0, 1'b1);
    wr(RB, 8'hFF);
    rd(RB, 8'hFF, ect_pkg::BT_WMASK);
    wr(RB, 8'h00);
    // stopped timer keeps a random written count
    d = $urandom % 256;
    wr(RM, 8'h70);
    wr(RC, d[7:0]);
    cy(40);
    rd(RC, 8'hFF, d[7:0]);
    // each rate: four ticks per four divisor periods
    for (int r = 0; r < 8; r++) begin
      wr(RM, 8'h80 | 8'(r << 4));
      acc(1'b0, RC, 32'h0, 32'h0, 32'h0, 1'b0);
      cy(4 * (256 >> r) - nb);
      rd(RC, 8'hFF, v[7:0] + 8'h04);
    end
    // rollover to zero keeps counting, raises the flag and the request
    wr(RM, 8'h70);
    wr(RS, 8'h10);
    wr(RC, 8'hFE);
    wr(RM, 8'hF0);
    cy(20);
    wr(RM, 8'h70);
    rd(RC, 8'hF0, 8'h00);
    rd(RS, 8'h13, 8'h11);
    chk("irq", 32'h1, {31'h0, timer_irq});
    wr(RS, 8'h11);
    rd(RS, 8'h13, 8'h10);
    cy(2);
    chk("irq", 32'h0, {31'h0, timer_irq});
    wr(RS, 8'h01);
    // auto-reload refills the counter at overflow
    wr(RR, 8'hF0);
    wr(RC, 8'hFC);
    wr(RM, 8'hF4);
    cy(16);
    wr(RM, 8'h74);
    rd(RC, 8'hF0, 8'hF0);
    // toggle output flips at overflow and owns the pin
    wr(RC, 8'hFC);
    wr(RM, 8'hF2);
    cy(2);
    lvl = waveform_pin_o;
    chk("pin enable", 32'h1, {31'h0, waveform_pin_oe});
    cy(12);
    chk("toggle", {31'h0, ~lvl}, {31'h0, waveform_pin_o});
    wr(RM, 8'hF0);
    cy(2);
    chk("pin enable", 32'h0, {31'h0, waveform_pin_oe});
    // pwm: every boundary, random duty, high time over one period
    for (int p = 0; p < 4; p++) begin
      bnd = (p == 0) ? 256 : (128 >> p);
      d = 1 + $urandom % (bnd - 1);
      wr(RM, 8'h00);
      wr(RC, 8'h00);
      wr(RR, d[7:0]);
      wr(RM, 8'hF1 | 8'(p << 1));
      cy(4 * bnd);
      h = 0;
      repeat (2 * bnd) begin
        @(posedge clk);
        if (waveform_pin_o === 1'b1) h++;
      end
      chk("pwm high", 32'(2 * d), 32'(h));
      chk("pin enable", 32'h1, {31'h0, waveform_pin_oe});
      rd(RC, ~8'(bnd - 1), 8'h00);
    end
    // external events: rate and pwm period ignored, pin flag held low
    wr(RM, 8'h00);
    wr(RS, 8'h03);
    wr(RC, 8'h0E);
    wr(RM, 8'hFF);
    repeat (5) fall();
    cy(6);
    rd(RC, 8'hFF, 8'h13);
    rd(RS, 8'h02, 8'h00);
    wr(RM, 8'h00);
    fall();
    rd(RS, 8'h02, 8'h02);
    wr(RS, 8'h02);
    rd(RS, 8'h02, 8'h00);
    // oscillator source, undivided then halved
    for (int k = 0; k < 2; k++) begin
      d = 2 * (10 + $urandom % 20);
      wr(RC, 8'h00);
      wr(RB, k ? 8'h04 : 8'h0C);
      wr(RM, 8'h88);
      hosc_en <= 1'b1;
      cy(d);
      hosc_en <= 1'b0;
      cy(4);
      wr(RM, 8'h00);
      rd(RC, 8'hFF, k ? 8'(d / 2) : 8'(d));
    end
    cy(4);
    end_of_test();
  end
endmodule
